// ==== hdl/i2cbf_pkg.sv ====
package i2cbf_pkg;
	// bus tracker states
	typedef enum logic [1:0] {I2CBF_IDLE, I2CBF_ACTIVE} i2cbf_bus_t;
	// slave byte engine states
	typedef enum logic [2:0] {I2CBF_S_WAIT, I2CBF_S_ADDR, I2CBF_S_ADDR_LO, I2CBF_S_RX, I2CBF_S_TX} i2cbf_slv_t;
	localparam int          I2CBF_CLK_HZ       = 50_000_000;
	localparam int          I2CBF_BITS         = 8;   // data bits per segment
	localparam int          I2CBF_SEG_BITS     = 9;   // data bits plus acknowledge
	localparam int          I2CBF_LONG_HOLD_NS = 300;
	localparam int          I2CBF_SHORT_HOLD_NS = 100;
	localparam int          I2CBF_NS_PER_CLK   = 1_000_000_000 / I2CBF_CLK_HZ;
	// least times round up to whole cycles
	localparam int          I2CBF_LONG_HOLD_CYC  = (I2CBF_LONG_HOLD_NS + I2CBF_NS_PER_CLK - 1) / I2CBF_NS_PER_CLK;
	localparam int          I2CBF_SHORT_HOLD_CYC = (I2CBF_SHORT_HOLD_NS + I2CBF_NS_PER_CLK - 1) / I2CBF_NS_PER_CLK;
	localparam logic [4:0]  I2CBF_TEN_BIT_HDR  = 5'h1e; // 11110 prefix of a ten-bit high byte
	localparam logic [7:0]  I2CBF_RST_ADDR     = 8'h00;
	localparam logic [3:0]  I2CBF_BIT_RST      = 4'h0;
	localparam int          I2CBF_ADDR_HI_MSB  = 2;  // upper ten-bit address bits sit in bits 2..1
	localparam int          I2CBF_ADDR_HI_LSB  = 1;
endpackage

// ==== hdl/i2cbf_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with edge detect on the second stage copy
module i2cbf_sync (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// pins idle high, so reset to the released level
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else if (clk_en) begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// ==== hdl/i2cbf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2cbf_top
	import i2cbf_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       module_enable_bit,
	input  wire logic       ten_bit_mode,
	input  wire logic       long_hold_select,
	input  wire logic [7:0] slave_address_register,
	input  wire logic [7:0] slave_address_low,
	input  wire logic       start_req,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_ack_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            scl_oe,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            bus_active,
	output logic            start_seen,
	output logic            stop_seen,
	output logic            collision,
	output logic            prior_match,
	output logic            addressed,
	output logic            read_dir,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_take,
	output logic            ack_seen_n
);
	logic       scl_lvl, scl_rise, scl_fall;
	logic       sda_lvl, sda_rise, sda_fall;
	i2cbf_bus_t bus_reg;
	i2cbf_slv_t slv_reg;
	logic       low_seen_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic       sda_drv_reg;
	logic       drv_pend_reg;
	logic       drv_val_reg;
	logic [4:0] hold_reg;
	logic       gen_start_reg;
	logic       acking_reg;
	logic       scl_hold_reg;
	logic       start_ev, stop_ev, active_run;

	// pins cross into the system clock before anything looks at them
	i2cbf_sync u_scl (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_in  (scl_in),
		.level   (scl_lvl),
		.rise    (scl_rise),
		.fall    (scl_fall)
	);
	i2cbf_sync u_sda (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_in  (sda_in),
		.level   (sda_lvl),
		.rise    (sda_rise),
		.fall    (sda_fall)
	);

	// true when the high address byte of a ten-bit address matches
	function automatic logic hi_match(input logic [7:0] b, input logic [7:0] a);
		hi_match = (b[7:3] == I2CBF_TEN_BIT_HDR) &&
			(b[I2CBF_ADDR_HI_MSB:I2CBF_ADDR_HI_LSB] == a[I2CBF_ADDR_HI_MSB:I2CBF_ADDR_HI_LSB]);
	endfunction

	assign active_run = module_enable_bit & clk_en;
	assign start_ev   = sda_fall & scl_lvl;
	assign stop_ev    = sda_rise & scl_lvl & low_seen_reg;

	// bus tracker: a restart is simply a start seen while active
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			bus_reg      <= I2CBF_IDLE;
			low_seen_reg <= 1'b0;
		end else if (clk_en) begin
			if (start_ev) begin
				bus_reg      <= I2CBF_ACTIVE;
				low_seen_reg <= 1'b0;
			end else if (stop_ev || (bus_reg == I2CBF_IDLE && sda_lvl && scl_lvl)) begin
				bus_reg      <= I2CBF_IDLE;
				low_seen_reg <= 1'b0;
			end else if (scl_fall) begin
				low_seen_reg <= 1'b1;
			end
		end
	end

	// event pulses and bus status for the controller
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
			bus_active <= 1'b0;
		end else if (clk_en) begin
			start_seen <= module_enable_bit & start_ev;
			stop_seen  <= module_enable_bit & stop_ev;
			// follow the tracker's next state so the start pulse and active level arrive together
			bus_active <= module_enable_bit & (start_ev | ((bus_reg == I2CBF_ACTIVE) & !stop_ev));
		end
	end

	// start generation: only while idle; a low data line under a high clock before we pull it is a collision
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			gen_start_reg <= 1'b0;
		end else if (clk_en) begin
			if (start_req && bus_reg == I2CBF_IDLE && sda_lvl) begin
				gen_start_reg <= 1'b1;
			end else if (!scl_lvl || stop_ev) begin
				gen_start_reg <= 1'b0; // master sequencing takes over once clock goes low
			end
		end
	end

	// collision detect, sticky until reset or disable; reset or disable beats any set
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			collision <= 1'b0;
		end else if (clk_en) begin
			if (start_req && bus_reg == I2CBF_IDLE && !sda_lvl && scl_lvl) begin
				collision <= 1'b1;
			end else if (scl_rise && slv_reg == I2CBF_S_TX && bit_reg < 4'(I2CBF_BITS) &&
					sda_oe == 1'b0 && sda_drv_reg && !sda_lvl && !acking_reg) begin
				collision <= 1'b1; // only while we are sending data bits
			end
		end
	end

	// slave byte engine: bit counter, shifter, address match, direction
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			slv_reg     <= I2CBF_S_WAIT;
			bit_reg     <= I2CBF_BIT_RST;
			shift_reg   <= I2CBF_RST_ADDR;
			prior_match <= 1'b0;
			addressed   <= 1'b0;
			read_dir    <= 1'b0;
			rx_valid    <= 1'b0;
			rx_data     <= I2CBF_RST_ADDR;
			tx_take     <= 1'b0;
			ack_seen_n  <= 1'b1;
		end else if (clk_en) begin
			rx_valid <= 1'b0;
			tx_take  <= 1'b0;
			if (start_ev) begin
				slv_reg   <= I2CBF_S_ADDR;
				bit_reg   <= I2CBF_BIT_RST;
				addressed <= 1'b0;
				read_dir  <= 1'b0;
			end else if (stop_ev) begin
				slv_reg     <= I2CBF_S_WAIT;
				addressed   <= 1'b0;
				prior_match <= 1'b0;
			end else if (scl_rise && slv_reg != I2CBF_S_WAIT) begin
				if (bit_reg < 4'(I2CBF_BITS)) begin
					shift_reg <= {shift_reg[6:0], sda_lvl};
					bit_reg   <= bit_reg + 4'h1;
				end else begin
					bit_reg <= I2CBF_BIT_RST; // ninth pulse is acknowledge
					case (slv_reg)
						I2CBF_S_ADDR: begin
							if (!ten_bit_mode) begin
								if (shift_reg[7:1] == slave_address_register[7:1]) begin
									addressed <= 1'b1;
									read_dir  <= shift_reg[0];
									slv_reg   <= shift_reg[0] ? I2CBF_S_TX : I2CBF_S_RX;
									tx_take   <= shift_reg[0];
								end else begin
									slv_reg <= I2CBF_S_WAIT;
								end
							end else if (hi_match(shift_reg, slave_address_register)) begin
								if (shift_reg[0] && prior_match) begin
									addressed <= 1'b1;
									read_dir  <= 1'b1;
									slv_reg   <= I2CBF_S_TX;
									tx_take   <= 1'b1;
								end else begin
									prior_match <= 1'b0;
									slv_reg     <= shift_reg[0] ? I2CBF_S_WAIT : I2CBF_S_ADDR_LO;
								end
							end else begin
								prior_match <= 1'b0;
								slv_reg     <= I2CBF_S_WAIT;
							end
						end
						I2CBF_S_ADDR_LO: begin
							if (shift_reg == slave_address_low) begin
								addressed   <= 1'b1;
								read_dir    <= 1'b0;
								prior_match <= 1'b1;
								slv_reg     <= I2CBF_S_RX;
							end else begin
								slv_reg <= I2CBF_S_WAIT;
							end
						end
						I2CBF_S_RX: begin
							rx_valid <= 1'b1;
							rx_data  <= shift_reg;
						end
						I2CBF_S_TX: begin
							ack_seen_n <= sda_lvl;
							if (sda_lvl) begin
								slv_reg <= I2CBF_S_WAIT; // master declined more
							end else begin
								tx_take <= 1'b1;
							end
						end
						default: slv_reg <= I2CBF_S_WAIT;
					endcase
				end
			end
		end
	end

	// transmit byte loads when the controller is asked for it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_reg <= I2CBF_RST_ADDR;
		end else if (clk_en && tx_take) begin
			tx_reg <= tx_data;
		end
	end

	// choose what to put on the data line after each falling clock; applied after the hold delay
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			drv_pend_reg <= 1'b0;
			drv_val_reg  <= 1'b1;
			acking_reg   <= 1'b0;
			hold_reg     <= 5'h00;
		end else if (clk_en) begin
			if (start_ev || stop_ev) begin
				drv_pend_reg <= 1'b1;
				drv_val_reg  <= 1'b1;
				acking_reg   <= 1'b0;
				hold_reg     <= 5'h00;
			end else if (scl_fall) begin
				drv_pend_reg <= 1'b1;
				hold_reg     <= long_hold_select ? 5'(I2CBF_LONG_HOLD_CYC) : 5'(I2CBF_SHORT_HOLD_CYC);
				if (bit_reg == 4'(I2CBF_BITS) && (slv_reg == I2CBF_S_RX ||
						(slv_reg == I2CBF_S_ADDR && ten_bit_mode) || slv_reg == I2CBF_S_ADDR_LO ||
						(slv_reg == I2CBF_S_ADDR && shift_reg[7:1] == slave_address_register[7:1]))) begin
					drv_val_reg <= (slv_reg == I2CBF_S_RX) ? tx_ack_n :
						(slv_reg == I2CBF_S_ADDR_LO) ? (shift_reg != slave_address_low) :
						(ten_bit_mode ? !hi_match(shift_reg, slave_address_register) : 1'b0);
					acking_reg  <= 1'b1;
				end else if (slv_reg == I2CBF_S_TX && bit_reg < 4'(I2CBF_BITS)) begin
					drv_val_reg <= tx_reg[3'(I2CBF_BITS - 1) - bit_reg[2:0]];
					acking_reg  <= 1'b0;
				end else begin
					drv_val_reg <= 1'b1; // release for acknowledge
					acking_reg  <= 1'b0;
				end
			end else if (hold_reg != 5'h00) begin
				hold_reg <= hold_reg - 5'h01;
			end else begin
				drv_pend_reg <= 1'b0;
			end
		end
	end

	// commit data drive once the hold time has passed
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			sda_drv_reg <= 1'b1;
		end else if (clk_en && drv_pend_reg && hold_reg == 5'h00) begin
			sda_drv_reg <= drv_val_reg;
		end
	end

	// clock held low for a cycle as each byte to send is picked up; never pulsed by us
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !module_enable_bit) begin
			scl_hold_reg <= 1'b0;
		end else if (clk_en) begin
			scl_hold_reg <= scl_fall & (slv_reg == I2CBF_S_TX) & (bit_reg == I2CBF_BIT_RST);
		end
	end

	// open-drain pins: value always zero, enable only to pull low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (clk_en) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe  <= active_run & scl_hold_reg;
			sda_oe  <= active_run & (gen_start_reg | !sda_drv_reg);
		end
	end
endmodule
`default_nettype wire

// ==== verification/i2cbf_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches the pins and flags of the framing block from outside
module i2cbf_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic module_enable_bit,
	input wire logic long_hold_select,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic bus_active,
	input wire logic start_seen,
	input wire logic stop_seen,
	input wire logic collision,
	input wire logic prior_match,
	input wire logic ack_seen_n
);
	logic [4:0] low_cnt_reg;
	logic       low_seen_reg;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst || !module_enable_bit);
	// length of the raw clock-low phase, saturating so it never wraps
	always_ff @(posedge clk_sys) begin
		if (sys_rst || scl_in)
			low_cnt_reg <= 5'h00;
		else if (low_cnt_reg != 5'h1f)
			low_cnt_reg <= low_cnt_reg + 5'h01;
	end
	// a raw start forgets any clock low; a stop needs one seen again
	always_ff @(posedge clk_sys) begin
		if (sys_rst || ($fell(sda_in) && scl_in))
			low_seen_reg <= 1'b0;
		else if (!scl_in)
			low_seen_reg <= 1'b1;
	end
	chk_pins_zero: assert property (
		scl_out == 1'b0 && sda_out == 1'b0) else $error("pin data value not zero");
	chk_start_flag: assert property (
		$fell(sda_in) && scl_in && $past(scl_in) |-> ##[2:5] start_seen) else $error("start not flagged");
	chk_start_active: assert property (
		start_seen |-> bus_active) else $error("start without active bus");
	chk_stop_idle: assert property (
		stop_seen |=> !bus_active && !prior_match) else $error("stop left bus active or match set");
	chk_stop_after_low: assert property (
		stop_seen |-> low_seen_reg) else $error("stop without clock low since start");
	chk_disable_clear: assert property (disable iff (sys_rst)
		!module_enable_bit |=> !bus_active && !sda_oe && !scl_oe && !collision && !prior_match)
		else $error("disable did not clear state");
	chk_reset_state: assert property (disable iff (1'b0)
		sys_rst |=> !bus_active && !sda_oe && !scl_oe && !collision && ack_seen_n) else $error("reset state wrong");
	// collision only where the line read low while this side let it float
	chk_collide_cause: assert property (
		$rose(collision) |-> !$past(sda_oe) && (!$past(sda_in, 2) || !$past(sda_in, 3) || !$past(sda_in, 4)))
		else $error("collision without a low data line");
	chk_hold_time: assert property (
		bus_active && !collision && $changed(sda_oe) |-> low_cnt_reg >= (long_hold_select ? 5'h0f : 5'h05))
		else $error("data changed inside hold time");
endmodule
bind i2cbf_top i2cbf_checker u_i2cbf_checker (.*);
`default_nettype wire

// ==== verification/i2cbf_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side bus master: it only pulls lines low, released lines float high
module i2cbf_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_oe,
	output logic      sda_oe
);
	int lo = 240; // clock low phase in ns, wide enough for the short device hold time; the bench sets 480 for the long one
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// step to a falling edge of the 20 ns bench clock so pin changes never meet a sampling edge
	task automatic to_quiet();
		if ($time % 20 != 0) #(20 - $time % 20);
	endtask
	// data falls while the clock is high, from idle or as a restart
	task automatic start_cond();
		to_quiet();
		sda_oe = 1'b0;
		#(lo) scl_oe = 1'b0;
		wait (scl);
		to_quiet();
		#40 sda_oe = 1'b1;
		#40 scl_oe = 1'b1;
	endtask
	// clock low first, then data low, then data rises while the clock is high
	task automatic stop_cond();
		to_quiet();
		scl_oe = 1'b1;
		#40 sda_oe = 1'b1;
		#(lo) scl_oe = 1'b0;
		wait (scl);
		to_quiet();
		#40 sda_oe = 1'b0;
		#160;
	endtask
	// data dips and returns with the clock high throughout
	task automatic glitch();
		to_quiet();
		#80 sda_oe = 1'b1;
		#80 sda_oe = 1'b0;
		#160;
	endtask
	// data pulled low under a low clock, then the clock let go: idle bus with data low, no start
	task automatic hold_low();
		to_quiet();
		scl_oe = 1'b1;
		#40 sda_oe = 1'b1;
		#40 scl_oe = 1'b0;
		#40;
	endtask
	// data changes mid-low; a stretched clock is waited out before sampling
	task automatic xfer_bit(input logic b, output logic s);
		to_quiet();
		#(lo / 2) sda_oe = ~b;
		#(lo / 2) scl_oe = 1'b0;
		wait (scl);
		to_quiet();
		#40 s = sda;
		#40 scl_oe = 1'b1;
	endtask
	task automatic xfer_byte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
		xfer_bit(a, k);
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_i2c_bus_condition_framing.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_i2c_bus_condition_framing;
	logic       clk_sys = 1'b0, sys_rst = 1'b1, module_enable_bit = 1'b1, ten_bit_mode = 1'b0;
	logic       long_hold_select = 1'b0, start_req = 1'b0, clk_en = 1'b1;
	logic       scl_oe, sda_oe, bus_active, stop_seen, collision, prior_match, addressed, read_dir, rx_valid;
	logic       ack_seen_n, m_scl_oe, m_sda_oe;
	logic [7:0] rx_data, got_rx;
	wire        scl = ~(scl_oe | m_scl_oe);
	wire        sda = ~(sda_oe | m_sda_oe);
	int         error_cnt = 0, checks_done = 0, n_stop = 0, n_hold = 0;
	// addresses against slave register 5a with expected {addressed, read}
	logic [7:0] row_addr [4] = '{8'h5a, 8'h5b, 8'h58, 8'hda};
	logic [1:0] row_exp [4]  = '{2'b10, 2'b11, 2'b00, 2'b00};
	i2cbf_top u_i2cbf_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .module_enable_bit(module_enable_bit),
		.ten_bit_mode(ten_bit_mode), .long_hold_select(long_hold_select), .slave_address_register(8'h5a),
		.slave_address_low(8'h34), .start_req(start_req), .tx_data(8'h96), .tx_ack_n(1'b0), .scl_in(scl),
		.sda_in(sda), .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .bus_active(bus_active),
		.start_seen(), .stop_seen(stop_seen), .collision(collision), .prior_match(prior_match),
		.addressed(addressed), .read_dir(read_dir), .rx_valid(rx_valid), .rx_data(rx_data), .tx_take(),
		.ack_seen_n(ack_seen_n));
	i2cbf_master_model u_i2cbf_master_model (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	initial forever #10 clk_sys = ~clk_sys;
	// one-cycle pulses are caught as they pass
	always @(posedge clk_sys) begin
		if (rx_valid) got_rx <= rx_data;
		if (stop_seen) n_stop <= n_stop + 1;
		if (scl_oe) n_hold <= n_hold + 1;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic set_enable(input logic v);
		@(posedge clk_sys) module_enable_bit <= v;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic req_start();
		@(posedge clk_sys) start_req <= 1'b1;
		@(posedge clk_sys) start_req <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	// address, then one data byte in the addressed direction where addressed, then stop
	task automatic run_row(input logic [7:0] a, input logic [1:0] e);
		logic [7:0] q;
		logic       k;
		int         s0;
		s0 = n_stop;
		u_i2cbf_master_model.start_cond();
		u_i2cbf_master_model.xfer_byte(a, 1'b1, q, k);
		repeat (3) @(posedge clk_sys);
		`CHK({k, addressed, read_dir}, {~e[1], e})
		if (e == 2'b10) begin
			u_i2cbf_master_model.xfer_byte(8'hc3, 1'b1, q, k);
			repeat (3) @(posedge clk_sys);
			`CHK({k, got_rx}, 9'h0c3)
		end
		if (e == 2'b11) begin
			u_i2cbf_master_model.xfer_byte(8'hff, 1'b1, q, k);
			repeat (4) @(posedge clk_sys);
			`CHK({q, ack_seen_n}, 9'h12d)
		end
		u_i2cbf_master_model.stop_cond();
		`CHK({bus_active, n_stop == s0 + 1}, 2'b01)
	endtask
	initial begin
		logic [7:0] q;
		logic       k;
		int         s;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		`CHK({bus_active, sda_oe, scl_oe, collision, ack_seen_n}, 5'b00001)
		// rows under both hold settings
		for (int h = 0; h < 2; h++) begin
			@(posedge clk_sys) long_hold_select <= h[0];
			u_i2cbf_master_model.lo = h ? 480 : 240;
			for (int r = 0; r < 4; r++) run_row(row_addr[r], row_exp[r]);
		end
		// ten-bit write match, restart into read, restart with a foreign high byte
		@(posedge clk_sys) ten_bit_mode <= 1'b1;
		u_i2cbf_master_model.start_cond();
		u_i2cbf_master_model.xfer_byte(8'hf2, 1'b1, q, k);
		`CHK(k, 1'b0)
		u_i2cbf_master_model.xfer_byte(8'h34, 1'b1, q, k);
		repeat (3) @(posedge clk_sys);
		`CHK({k, addressed, prior_match}, 3'b011)
		u_i2cbf_master_model.start_cond();
		repeat (3) @(posedge clk_sys);
		`CHK({addressed, prior_match}, 2'b01)
		s = n_hold;
		u_i2cbf_master_model.xfer_byte(8'hf3, 1'b1, q, k);
		repeat (3) @(posedge clk_sys);
		`CHK({k, addressed, read_dir}, 3'b011)
		u_i2cbf_master_model.xfer_byte(8'hff, 1'b1, q, k);
		`CHK({q, n_hold == s + 1}, 9'h12d)
		u_i2cbf_master_model.start_cond();
		u_i2cbf_master_model.xfer_byte(8'hf0, 1'b1, q, k);
		repeat (3) @(posedge clk_sys);
		`CHK({k, prior_match}, 2'b10)
		u_i2cbf_master_model.stop_cond();
		@(posedge clk_sys) ten_bit_mode <= 1'b0;
		// data dip with the clock high is a start only
		s = n_stop;
		u_i2cbf_master_model.glitch();
		`CHK({bus_active, n_stop == s}, 2'b11)
		u_i2cbf_master_model.stop_cond();
		`CHK(bus_active, 1'b0)
		// master holds data low while the device sends a one
		u_i2cbf_master_model.start_cond();
		u_i2cbf_master_model.xfer_byte(8'h5b, 1'b1, q, k);
		u_i2cbf_master_model.xfer_byte(8'h00, 1'b1, q, k);
		`CHK(collision, 1'b1)
		u_i2cbf_master_model.stop_cond();
		set_enable(1'b0);
		`CHK({collision, bus_active, sda_oe}, 3'b000)
		set_enable(1'b1);
		req_start();
		`CHK({sda_oe, collision, bus_active}, 3'b101)
		// a low clock enable freezes the pulled line and the active bus
		@(posedge clk_sys) clk_en <= 1'b0;
		repeat (5) @(posedge clk_sys);
		`CHK({sda_oe, bus_active}, 2'b11)
		@(posedge clk_sys) clk_en <= 1'b1;
		set_enable(1'b0);
		set_enable(1'b1);
		u_i2cbf_master_model.hold_low();
		req_start();
		`CHK({sda_oe, collision}, 2'b01)
		set_enable(1'b0);
		set_enable(1'b1);
		u_i2cbf_master_model.stop_cond();
		final_report();
	end
	// a hang is cut short well beyond the expected run
	initial begin
		#1_000_000;
		error_cnt++;
		final_report();
	end
endmodule
`default_nettype wire
